// file: hdl/fptu_tangent_unit.v
// Tangent instruction unit: decodes, converts, dispatches, writes back.
// Assumes the host has fetched any memory operand into the operand
// registers before writing the instruction; the numeric kernel sits
// outside on the tan* ports and answers with tanDone.
//
// How it works
// [RULE1] Execute only when the coprocessor id matches this unit.
// [RULE2] Extension opmode 0001111 selects the tangent operation.
// [RULE3] Select bit 0: source comes from a data register.
// [RULE4] Select bit 1: source from effective address, result to register.
// [RULE5] Issuer drives effective address zero for register form.
// [RULE6] Memory form decodes the seven source format codes.
// [RULE7] Register form: specifier names the source data register.
// [RULE8] Data-register mode only for byte, word, long, single; no An.
// [RULE9] Decode memory modes and mode-seven register sub-modes.
// [RULE10] Convert non-extended sources to extended precision first.
// [RULE11] Tangent result goes to the destination data register.
// [RULE12] Sources beyond half pi are reduced before evaluation.
// [RULE13] Zero source gives zero of the same sign.
// [RULE14] Infinite source gives NaN and operand error; else cleared.
// [RULE15] Clear branch-unordered and divide-by-zero; keep quotient.
// [RULE16] Decimal-input inexact only for packed sources.
// [RULE17] Condition codes follow the result value.
// [RULE18] Accrued byte gathers this instruction's exceptions.
// [RULE19] Equal source and destination overwrite the same register.
`include "fptu_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module fptu_tangent_unit (
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire irq,
  output reg tanStart,
  output reg [79:0] tanArg,
  output reg tanReduce,
  output reg tanPacked,
  output reg [95:0] tanPackedSrc,
  input wire tanDone,
  input wire [79:0] tanResult,
  input wire tanOvfl,
  input wire tanUnfl,
  input wire tanInex,
  input wire tanDecInexact
);
  localparam ST_IDLE = 2'b00;
  localparam ST_DEC = 2'b01;
  localparam ST_KERN = 2'b10;
  localparam ST_WB = 2'b11;

  // ********************************
  // Bus slave
  // ********************************
  reg wrEn_r;
  reg [7:0] wrAddr_r;
  reg [1:0] state_r;
  reg [31:0] instr_r;
  reg [31:0] opnd0_r;
  reg [31:0] opnd1_r;
  reg [31:0] opnd2_r;
  reg [3:0] cc_r;
  reg [7:0] quot_r;
  reg [7:0] exc_r;
  reg [7:0] accr_r;
  reg [2:0] irqSt_r;
  reg [2:0] irqMask_r;
  reg [2:0] cpId_r;
  reg [2:0] fpSel_r;
  reg [79:0] res_r;
  reg resOvfl_r;
  reg resUnfl_r;
  reg resInex_r;
  reg resDec_r;
  reg resOperr_r;
  reg resSnan_r;
  reg [2:0] irqEv;
  wire [79:0] fpRegQ [0:7];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irqSt_r & irqMask_r);

  wire addrPh = hsel & htrans[1] & hready;
  wire wr = wrEn_r;
  wire busy = (state_r != ST_IDLE);
  wire instrWr = wr & (wrAddr_r == `FPTU_OFS_INSTR);

  // Instruction fields: low half first word, high half extension
  wire [3:0] fLine = instr_r[15:12];
  wire [2:0] fCpId = instr_r[11:9];
  wire [2:0] fType = instr_r[8:6];
  wire [2:0] eaMode = instr_r[5:3];
  wire [2:0] eaReg = instr_r[2:0];
  wire xTop = instr_r[31];
  wire rmSel = instr_r[30];
  wire xBit13 = instr_r[29];
  wire [2:0] srcSpec = instr_r[28:26];
  wire [2:0] dstReg = instr_r[25:23];
  wire [6:0] opMode = instr_r[22:16];

  reg [31:0] rdMux;
  wire [79:0] selQ = fpRegQ[fpSel_r];
  always @* begin
    case (haddr[7:0])
      `FPTU_OFS_INSTR: rdMux = instr_r;
      `FPTU_OFS_OPND0: rdMux = opnd0_r;
      `FPTU_OFS_OPND1: rdMux = opnd1_r;
      `FPTU_OFS_OPND2: rdMux = opnd2_r;
      `FPTU_OFS_FPSR: rdMux = {4'h0, cc_r, quot_r, exc_r, accr_r};
      `FPTU_OFS_IRQST: rdMux = {29'h0, irqSt_r};
      `FPTU_OFS_IRQMSK: rdMux = {29'h0, irqMask_r};
      `FPTU_OFS_CPID: rdMux = {29'h0, cpId_r};
      `FPTU_OFS_FPSEL: rdMux = {29'h0, fpSel_r};
      `FPTU_OFS_FPHI: rdMux = {16'h0, selQ[79:64]};
      `FPTU_OFS_FPMID: rdMux = selQ[63:32];
      `FPTU_OFS_FPLO: rdMux = selQ[31:0];
      // Exactly one word: busy at bit 16, upper 15 bits zero, destination not shown
      `FPTU_OFS_INFO: rdMux = {15'h0, busy, 2'h0, state_r,
        1'b0, eaMode, 1'b0, eaReg, 1'b0, srcSpec};
      default: rdMux = 32'h0;
    endcase
  end

  // Read data is prepared in the address phase so no wait state is needed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrEn_r <= 1'b0;
      wrAddr_r <= 8'h0;
      hrdata <= 32'h0;
    end else begin
      wrEn_r <= addrPh & hwrite;
      wrAddr_r <= haddr[7:0];
      if (addrPh & ~hwrite)
        hrdata <= rdMux;
    end
  end

  // ********************************
  // Decode and legality
  // ********************************
  // [RULE1] Coprocessor id match
  wire isOurs = (fLine == `FPTU_LINE_F) & (fCpId == cpId_r) &
    (fType == 3'h0) & ~xTop & ~xBit13;
  // [RULE2] Tangent opmode
  wire isTan = (opMode == `FPTU_OPMODE_TAN);
  // [RULE8] Data-register direct only for short formats
  wire shortFmt = (srcSpec == `FPTU_FMT_L) | (srcSpec == `FPTU_FMT_S) |
    (srcSpec == `FPTU_FMT_W) | (srcSpec == `FPTU_FMT_B);
  // [RULE9] Mode seven register codes above immediate are undefined
  wire eaOk = (eaMode == `FPTU_EA_DREG) ? shortFmt :
    (eaMode == `FPTU_EA_AREG) ? 1'b0 :
    (eaMode == `FPTU_EA_EXT) ? (eaReg <= `FPTU_EAR_IMM) : 1'b1;
  // [RULE6] Code 111 is no format
  wire fmtOk = (srcSpec != 3'h7);
  // [RULE3] [RULE4] [RULE5] Register form ignores the address field
  wire legal = isTan & (~rmSel | (eaOk & fmtOk));

  // ********************************
  // Conversion to extended
  // ********************************
  reg cvSign;
  reg [14:0] cvExp;
  reg [63:0] cvMant;
  reg [31:0] intVal;
  reg [31:0] intMag;
  reg [5:0] lz;
  reg [63:0] intShift;
  integer k;
  // [RULE10] Every format but packed widened to 80 bits; packed goes to the kernel as 96 bits
  always @* begin
    cvSign = 1'b0;
    cvExp = 15'h0;
    cvMant = 64'h0;
    lz = 6'd32;
    intShift = 64'h0;
    case (srcSpec)
      `FPTU_FMT_B: intVal = {{24{opnd0_r[7]}}, opnd0_r[7:0]};
      `FPTU_FMT_W: intVal = {{16{opnd0_r[15]}}, opnd0_r[15:0]};
      default: intVal = opnd0_r;
    endcase
    intMag = intVal[31] ? (~intVal + 32'h1) : intVal;
    for (k = 0; k < 32; k = k + 1)
      if (intMag[k])
        lz = 6'd31 - k[5:0];
    // [RULE7] [RULE19] Register form reads the named data register
    if (!rmSel) begin
      cvSign = fpRegQ[srcSpec][79];
      cvExp = fpRegQ[srcSpec][78:64];
      cvMant = fpRegQ[srcSpec][63:0];
    end else begin
      case (srcSpec)
        `FPTU_FMT_S: begin
          cvSign = opnd0_r[31];
          if (opnd0_r[30:23] == 8'hff) begin
            cvExp = `FPTU_EXP_MAX;
            cvMant = {1'b1, opnd0_r[22:0], 40'h0};
          end else if (opnd0_r[30:23] == 8'h0) begin
            cvExp = (opnd0_r[22:0] == 23'h0) ? 15'h0 : `FPTU_DENS_S;
            cvMant = {1'b0, opnd0_r[22:0], 40'h0};
          end else begin
            cvExp = {7'h0, opnd0_r[30:23]} + `FPTU_BIAS_S;
            cvMant = {1'b1, opnd0_r[22:0], 40'h0};
          end
        end
        `FPTU_FMT_D: begin
          cvSign = opnd0_r[31];
          if (opnd0_r[30:20] == 11'h7ff) begin
            cvExp = `FPTU_EXP_MAX;
            cvMant = {1'b1, opnd0_r[19:0], opnd1_r, 11'h0};
          end else if (opnd0_r[30:20] == 11'h0) begin
            cvExp = ({opnd0_r[19:0], opnd1_r} == 52'h0) ? 15'h0 :
              `FPTU_DEN_D;
            cvMant = {1'b0, opnd0_r[19:0], opnd1_r, 11'h0};
          end else begin
            cvExp = {4'h0, opnd0_r[30:20]} + `FPTU_BIAS_D;
            cvMant = {1'b1, opnd0_r[19:0], opnd1_r, 11'h0};
          end
        end
        `FPTU_FMT_X, `FPTU_FMT_P: begin
          cvSign = opnd0_r[31];
          cvExp = opnd0_r[30:16];
          cvMant = {opnd1_r, opnd2_r};
        end
        default: begin
          cvSign = intVal[31];
          intShift = {intMag, 32'h0} << lz;
          cvMant = intShift;
          cvExp = (intMag == 32'h0) ? 15'h0 :
            (`FPTU_BIAS_INT - {9'h0, lz});
        end
      endcase
    end
  end

  wire isPacked = rmSel & (srcSpec == `FPTU_FMT_P);
  wire isZero = (cvExp == 15'h0) & (cvMant == 64'h0);
  wire isMaxE = (cvExp == `FPTU_EXP_MAX);
  wire isInf = isMaxE & (cvMant[62:0] == 63'h0);
  wire isNan = isMaxE & ~isInf;
  // [RULE12] Beyond half pi the kernel must reduce first
  wire bigArg = ({cvExp, cvMant} > `FPTU_HALFPI);

  // ********************************
  // Sequencer
  // ********************************
  // A new instruction while busy is refused, never queued
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      instr_r <= 32'h0;
      tanStart <= 1'b0;
      tanArg <= 80'h0;
      tanReduce <= 1'b0;
      tanPacked <= 1'b0;
      tanPackedSrc <= 96'h0;
      res_r <= 80'h0;
      resOvfl_r <= 1'b0;
      resUnfl_r <= 1'b0;
      resInex_r <= 1'b0;
      resDec_r <= 1'b0;
      resOperr_r <= 1'b0;
      resSnan_r <= 1'b0;
    end else begin
      tanStart <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (instrWr) begin
            instr_r <= hwdata;
            state_r <= ST_DEC;
          end
        end
        ST_DEC: begin
          resOvfl_r <= 1'b0;
          resUnfl_r <= 1'b0;
          resInex_r <= 1'b0;
          resDec_r <= 1'b0;
          resOperr_r <= 1'b0;
          resSnan_r <= 1'b0;
          if (!isOurs || !legal) begin
            state_r <= ST_IDLE;
          end else if (isPacked) begin
            tanPacked <= 1'b1;
            tanPackedSrc <= {opnd0_r, opnd1_r, opnd2_r};
            tanReduce <= 1'b0;
            tanStart <= 1'b1;
            state_r <= ST_KERN;
          end else if (isZero) begin
            // [RULE13] Signed zero passes through
            res_r <= {cvSign, 79'h0};
            state_r <= ST_WB;
          end else if (isInf) begin
            // [RULE14] Infinity has no tangent
            res_r <= `FPTU_QNAN;
            resOperr_r <= 1'b1;
            state_r <= ST_WB;
          end else if (isNan) begin
            res_r <= {cvSign, cvExp, cvMant[63], 1'b1, cvMant[61:0]};
            resSnan_r <= ~cvMant[62];
            state_r <= ST_WB;
          end else begin
            // [RULE11] Kernel evaluates the tangent
            tanPacked <= 1'b0;
            tanArg <= {cvSign, cvExp, cvMant};
            tanReduce <= bigArg;
            tanStart <= 1'b1;
            state_r <= ST_KERN;
          end
        end
        ST_KERN: begin
          if (tanDone) begin
            res_r <= tanResult;
            resOvfl_r <= tanOvfl;
            resUnfl_r <= tanUnfl;
            resInex_r <= tanInex;
            // [RULE16] Decimal inexact only for packed input
            resDec_r <= tanPacked & tanDecInexact;
            state_r <= ST_WB;
          end
        end
        ST_WB: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ********************************
  // Data registers
  // ********************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gFpReg
      reg [79:0] q_r;
      // [RULE11] [RULE19] Destination written once, after the read
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
          q_r <= 80'h0;
        else if (state_r == ST_WB && dstReg == g)
          q_r <= res_r;
      end
      assign fpRegQ[g] = q_r;
    end
  endgenerate

  // ********************************
  // Status, interrupts, config
  // ********************************
  wire resZero = (res_r[78:0] == 79'h0);
  wire resMaxE = (res_r[78:64] == `FPTU_EXP_MAX);
  wire resInf = resMaxE & (res_r[62:0] == 63'h0);
  wire resNan = resMaxE & ~resInf;
  wire wb = (state_r == ST_WB);
  // Unordered, sig NaN, operand, ovfl, unfl, divide, inexact, decimal
  // [RULE15] Branch-unordered and divide-by-zero held clear
  wire [7:0] newExc = {1'b0, resSnan_r, resOperr_r, resOvfl_r,
    resUnfl_r, 1'b0, resInex_r, resDec_r};

  always @* begin
    irqEv = 3'h0;
    irqEv[`FPTU_IRQ_DONE] = wb;
    irqEv[`FPTU_IRQ_OPERAND_ERROR_FLAG] = wb & resOperr_r;
    irqEv[`FPTU_IRQ_REJ] = (state_r == ST_DEC) & ~(isOurs & legal);
    irqEv[`FPTU_IRQ_REJ] = irqEv[`FPTU_IRQ_REJ] | (instrWr & busy);
  end

  // Hardware updates win over a same-cycle software write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cc_r <= 4'h0;
      quot_r <= 8'h0;
      exc_r <= 8'h0;
      accr_r <= 8'h0;
      irqSt_r <= 3'h0;
      irqMask_r <= 3'h0;
      cpId_r <= `FPTU_CPID_RST;
      fpSel_r <= 3'h0;
      opnd0_r <= 32'h0;
      opnd1_r <= 32'h0;
      opnd2_r <= 32'h0;
    end else begin
      if (wr) begin
        case (wrAddr_r)
          `FPTU_OFS_OPND0: opnd0_r <= hwdata;
          `FPTU_OFS_OPND1: opnd1_r <= hwdata;
          `FPTU_OFS_OPND2: opnd2_r <= hwdata;
          `FPTU_OFS_IRQMSK: irqMask_r <= hwdata[2:0];
          `FPTU_OFS_CPID: cpId_r <= hwdata[2:0];
          `FPTU_OFS_FPSEL: fpSel_r <= hwdata[2:0];
          `FPTU_OFS_FPSR: begin
            cc_r <= hwdata[27:24];
            quot_r <= hwdata[23:16];
            exc_r <= hwdata[15:8];
            accr_r <= hwdata[7:0];
          end
          default: ;
        endcase
      end
      irqSt_r <= (irqSt_r &
        ~((wr && wrAddr_r == `FPTU_OFS_IRQST) ? hwdata[2:0] : 3'h0))
        | irqEv;
      if (wb) begin
        // [RULE17] N Z I NAN from the result
        cc_r <= {res_r[79], resZero, resInf, resNan};
        // [RULE14] [RULE15] [RULE16] Whole exception byte rewritten
        exc_r <= newExc;
        // [RULE18] Invalid, overflow, underflow, divide, inexact accumulate
        accr_r <= accr_r | {resSnan_r | resOperr_r, resOvfl_r,
          resUnfl_r & resInex_r, 1'b0,
          resInex_r | resDec_r | resOvfl_r, 3'h0};
      end
    end
  end
endmodule
`default_nettype wire

// file: pkg/fptu_defs.vh
// Constants for the floating-point tangent instruction unit.
// Assumes a 32-bit AHB-Lite register bus and 80-bit extended format.
`ifndef FPTU_DEFS_VH
`define FPTU_DEFS_VH
// ********************************
// Register byte offsets
// ********************************
`define FPTU_OFS_INSTR 8'h00
`define FPTU_OFS_OPND0 8'h04
`define FPTU_OFS_OPND1 8'h08
`define FPTU_OFS_OPND2 8'h0c
`define FPTU_OFS_FPSR 8'h10
`define FPTU_OFS_IRQST 8'h14
`define FPTU_OFS_IRQMSK 8'h18
`define FPTU_OFS_CPID 8'h1c
`define FPTU_OFS_FPSEL 8'h20
`define FPTU_OFS_FPHI 8'h24
`define FPTU_OFS_FPMID 8'h28
`define FPTU_OFS_FPLO 8'h2c
`define FPTU_OFS_INFO 8'h30
// ********************************
// Instruction fields and codes
// ********************************
`define FPTU_LINE_F 4'hf
`define FPTU_OPMODE_TAN 7'h0f
`define FPTU_CPID_RST 3'h1
`define FPTU_FMT_L 3'h0
`define FPTU_FMT_S 3'h1
`define FPTU_FMT_X 3'h2
`define FPTU_FMT_P 3'h3
`define FPTU_FMT_W 3'h4
`define FPTU_FMT_D 3'h5
`define FPTU_FMT_B 3'h6
`define FPTU_EA_DREG 3'h0
`define FPTU_EA_AREG 3'h1
`define FPTU_EA_EXT 3'h7
`define FPTU_EAR_IMM 3'h4
// ********************************
// Numeric constants
// ********************************
`define FPTU_BIAS_INT 15'h401e
`define FPTU_BIAS_S 15'h3f80
`define FPTU_DENS_S 15'h3f81
`define FPTU_BIAS_D 15'h3c00
`define FPTU_DEN_D 15'h3c01
`define FPTU_EXP_MAX 15'h7fff
`define FPTU_HALFPI 79'h3fffc90fdaa22168c235
`define FPTU_QNAN 80'h7fffc000000000000000
`define FPTU_IRQ_DONE 0
`define FPTU_IRQ_OPERAND_ERROR_FLAG 1
`define FPTU_IRQ_REJ 2
`endif

// file: tb/fptu_tangent_unit_checker.sv
// Concurrent checks on the tangent unit's bus and kernel ports.
// Assumes one clock domain; bound to the unit at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
`include "fptu_defs.vh"
module fptu_tangent_unit_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq,
  input wire logic tanStart,
  input wire logic [79:0] tanArg,
  input wire logic tanReduce,
  input wire logic tanPacked
);
  logic addrOk;
  logic instrWr;
  logic maskWr_r;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  assign addrOk = hsel && htrans[1] && hready;
  assign instrWr = addrOk && hwrite && haddr[7:0] == `FPTU_OFS_INSTR;
  // Mask data is only on the bus one cycle after its address phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      maskWr_r <= 1'h0;
    else
      maskWr_r <= addrOk && hwrite && haddr[7:0] == `FPTU_OFS_IRQMSK;
  end
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_unmapped_zero: assert property (
    addrOk && !hwrite && haddr[7:2] > 6'h0c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_start_cause: assert property (
    tanStart |-> $past(instrWr, 2) || $past(instrWr, 3))
    else $error("kernel start without instruction write");
  a_start_pulse: assert property (tanStart |=> !tanStart)
    else $error("kernel start longer than one cycle");
  a_args_hold: assert property (
    !tanStart |-> $stable(tanArg) && $stable(tanReduce) && $stable(tanPacked))
    else $error("kernel arguments moved without start");
  // Packed sources are converted by the kernel, so skip them here
  a_reduce_flag: assert property (
    tanStart && !tanPacked |-> tanReduce == (tanArg[78:0] > `FPTU_HALFPI))
    else $error("reduction flag wrong");
  a_special_local: assert property (
    tanStart && !tanPacked |-> tanArg[78:64] != 15'h7fff
      && tanArg[78:0] != 79'h0)
    else $error("special value sent to kernel");
  a_mask_quiet: assert property (maskWr_r && hwdata == 32'h0 |=> !irq)
    else $error("irq high with all masked");
endmodule
bind fptu_tangent_unit fptu_tangent_unit_checker u_chk (.clk, .reset_n,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .irq, .tanStart, .tanArg, .tanReduce, .tanPacked);
`default_nettype wire

// file: tb/fptu_kernel_model.sv
// Stand-in for the numeric tangent kernel on the unit's tan ports.
// Assumes one start at a time; answer delay alternates 1 and 6 cycles.
`timescale 1ns/10ps
`default_nettype none
module fptu_kernel_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tanStart,
  input wire logic [79:0] tanArg,
  input wire logic tanPacked,
  output logic tanDone,
  output logic [79:0] tanResult,
  output logic tanOvfl,
  output logic tanUnfl,
  output logic tanInex,
  output logic tanDecInexact
);
  int waitCnt;
  bit slow;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 0;
      slow <= 1'h0;
      tanDone <= 1'h0;
    end else if (tanStart) begin
      waitCnt <= slow ? 6 : 1;
      slow <= !slow;
    end else begin
      tanDone <= waitCnt == 1;
      if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
    end
  end
  // Result marked by its argument
  // Argument plus one lets the bench trace which operand was used;
  // outside the answer every line shows the inverse so stale data fails
  assign tanResult = tanDone ? tanArg + 80'h1 : ~(tanArg + 80'h1);
  assign tanInex = tanDone;
  assign tanOvfl = !tanDone;
  assign tanUnfl = !tanDone;
  assign tanDecInexact = tanDone ? tanPacked : !tanPacked;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Bench for the tangent unit: register tasks and scenario sequences.
// Assumes the kernel model sits on the tan ports; one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "fptu_defs.vh"
module tb;
  localparam logic [79:0] ONE = 80'h3fff8000000000000000;
  localparam logic [6:0] TAN = `FPTU_OPMODE_TAN;
  logic clk, reset_n, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rdv;
  wire [31:0] hrdata;
  wire hready, hresp, irq, tanStart, tanReduce, tanPacked, tanDone;
  wire tanOvfl, tanUnfl, tanInex, tanDecInexact;
  wire [79:0] tanArg, tanResult;
  wire [95:0] tanPackedSrc;
  int err_total, checks_done;
  // Source spec, ea mode, ea register; every row converts to one
  logic [8:0] dec[10] = '{9'h003, 9'h051, 9'h09a, 9'h125, 9'h168, 9'h1b7,
    9'h038, 9'h039, 9'h07a, 9'h13b};
  logic [31:0] src[10] = '{32'h1, 32'h3f800000, 32'h3fff0000, 32'h1,
    32'h3ff00000, 32'h1, 32'h1, 32'h1, 32'h3f800000, 32'h1};
  logic [31:0] zin[4] = '{32'h0, 32'h80000000, 32'h7fff0000, 32'hffff0000};
  logic [31:0] zfs[4] = '{32'h045a0040, 32'h0c5a0040, 32'h015a20c0,
    32'h015a20c0};
  fptu_tangent_unit u_fptu_tangent_unit (.clk, .reset_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .irq, .tanStart, .tanArg, .tanReduce, .tanPacked,
    .tanPackedSrc, .tanDone, .tanResult, .tanOvfl, .tanUnfl, .tanInex,
    .tanDecInexact);
  fptu_kernel_model u_fptu_kernel_model (.clk, .reset_n, .tanStart,
    .tanArg, .tanPacked, .tanDone, .tanResult, .tanOvfl, .tanUnfl,
    .tanInex, .tanDecInexact);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [95:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic chk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    rd(a);
    cmp(n, e, rdv);
  endtask
  task automatic fp(input logic [2:0] i, input logic [79:0] e);
    logic [79:0] v;
    wr(`FPTU_OFS_FPSEL, {29'h0, i});
    rd(`FPTU_OFS_FPHI);
    v[79:64] = rdv[15:0];
    rd(`FPTU_OFS_FPMID);
    v[63:32] = rdv;
    rd(`FPTU_OFS_FPLO);
    v[31:0] = rdv;
    cmp("fpreg", e, v);
  endtask
  function automatic logic [31:0] mk(input logic [2:0] cp, md, rg, sp, ds,
    input logic rm, input logic [6:0] op);
    return {1'h0, rm, 1'h0, sp, ds, op, 4'hf, cp, 3'h0, md, rg};
  endfunction
  // Poll busy; a poll that runs out counts as a mismatch
  task automatic idle();
    rdv = 32'h10000;
    for (int k = 0; k < 40 && rdv[16] !== 1'h0; k++)
      rd(`FPTU_OFS_INFO);
    cmp("busy", 32'h0, rdv & 32'h10000);
  endtask
  // Stale flags, an accrued overflow and a quotient must survive or clear
  task automatic run(input logic [31:0] ins, o0, o1);
    wr(`FPTU_OFS_IRQST, 32'h7);
    wr(`FPTU_OFS_FPSR, 32'h005aa440);
    wr(`FPTU_OFS_OPND0, o0);
    wr(`FPTU_OFS_OPND1, o1);
    wr(`FPTU_OFS_OPND2, 32'h0);
    wr(`FPTU_OFS_INSTR, ins);
    idle();
  endtask
  task automatic refuse(input logic [31:0] ins);
    run(ins, 32'h1, 32'h0);
    chk("fpsr", `FPTU_OFS_FPSR, 32'h005aa440);
    rd(`FPTU_OFS_IRQST);
    cmp("reject", 32'h4, rdv & 32'h4);
    fp(3'h0, ONE + 80'h1);
  endtask
  task automatic irqIs(input logic e);
    @(negedge clk);
    cmp("irq", e, irq);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    reset_n = 1'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    chk("cpid", `FPTU_OFS_CPID, 32'h1);
    chk("fpsr", `FPTU_OFS_FPSR, 32'h0);
    chk("irqst", `FPTU_OFS_IRQST, 32'h0);
    chk("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 10; i++) begin
      run(mk(3'h1, dec[i][5:3], dec[i][2:0], dec[i][8:6], i[2:0], 1'h1, TAN),
        src[i], i == 2 ? 32'h80000000 : 32'h0);
      cmp("arg", ONE, tanArg);
      cmp("reduce", 1'h0, tanReduce);
      chk("fpsr", `FPTU_OFS_FPSR, 32'h005a0248);
      fp(i[2:0], ONE + 80'h1);
    end
    run(mk(3'h1, 3'h7, 3'h4, `FPTU_FMT_L, 3'h3, 1'h1, TAN), 32'h4, 32'h0);
    cmp("arg", 80'h40018000000000000000, tanArg);
    cmp("reduce", 1'h1, tanReduce);
    run(mk(3'h1, 3'h7, 3'h4, `FPTU_FMT_P, 3'h3, 1'h1, TAN), 32'h1, 32'h0);
    cmp("packed", 1'h1, tanPacked);
    cmp("pksrc", {32'h1, 64'h0}, tanPackedSrc);
    chk("fpsr", `FPTU_OFS_FPSR, 32'h005a0348);
    run(mk(3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 1'h0, TAN), 32'h0, 32'h0);
    cmp("arg", ONE + 80'h1, tanArg);
    fp(3'h2, ONE + 80'h2);
    run(mk(3'h1, 3'h0, 3'h0, 3'h2, 3'h5, 1'h0, TAN), 32'h0, 32'h0);
    fp(3'h5, ONE + 80'h3);
    fp(3'h2, ONE + 80'h2);
    for (int i = 0; i < 4; i++) begin
      run(mk(3'h1, 3'h7, 3'h4, i > 0 ? `FPTU_FMT_X : `FPTU_FMT_L, 3'h4,
        1'h1, TAN), zin[i], 32'h0);
      chk("fpsr", `FPTU_OFS_FPSR, zfs[i]);
      if (i < 3)
        fp(3'h4, i < 2 ? {zin[i][31:16], 64'h0} : `FPTU_QNAN);
    end
    chk("irqst", `FPTU_OFS_IRQST, 32'h3);
    irqIs(1'h0);
    wr(`FPTU_OFS_IRQMSK, 32'h2);
    irqIs(1'h1);
    wr(`FPTU_OFS_IRQST, 32'h2);
    irqIs(1'h0);
    chk("irqst", `FPTU_OFS_IRQST, 32'h1);
    wr(`FPTU_OFS_IRQMSK, 32'h0);
    refuse(mk(3'h2, 3'h7, 3'h4, 3'h0, 3'h0, 1'h1, TAN));
    refuse(mk(3'h1, 3'h7, 3'h4, 3'h0, 3'h0, 1'h1, 7'h10));
    refuse(mk(3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 1'h1, TAN));
    refuse(mk(3'h1, 3'h0, 3'h0, 3'h2, 3'h0, 1'h1, TAN));
    refuse(mk(3'h1, 3'h7, 3'h5, 3'h0, 3'h0, 1'h1, TAN));
    // A second instruction while the kernel runs is dropped and flagged
    wr(`FPTU_OFS_IRQST, 32'h7);
    wr(`FPTU_OFS_INSTR, mk(3'h1, 3'h0, 3'h0, 3'h2, 3'h6, 1'h0, TAN));
    wr(`FPTU_OFS_INSTR, mk(3'h1, 3'h0, 3'h0, 3'h5, 3'h7, 1'h0, TAN));
    rd(`FPTU_OFS_IRQST);
    cmp("busyrej", 32'h4, rdv & 32'h4);
    idle();
    fp(3'h6, ONE + 80'h3);
    fp(3'h7, ONE + 80'h1);
    test_done();
  end
endmodule
`default_nettype wire
